// ### rtl/slf_top.sv
// Switch core: address learning and aging, two-stage forwarding, buffer
// accounting, one port's transmit timing, and an AHB-Lite register slave.
// Assumes frame descriptors arrive at end of frame and ports are numbered 0..4.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

module slf_top
  import slf_pkg::*;
#(
  parameter int MS_CYCLES = DEF_MS_CYCLES,
  parameter int TICK_MS = DEF_TICK_MS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [47:0] rx_sa,
  input wire logic [47:0] rx_da,
  input wire logic [2:0] rx_port,
  input wire logic [10:0] rx_len,
  input wire logic rx_err,
  input wire logic rx_pause,
  input wire logic rx_vlan_tag,
  output logic fwd_valid,
  output logic [4:0] first_stage_port_map,
  output logic [4:0] final_port_map,
  output logic [4:0] fwd_buffers,
  input wire logic buf_release,
  input wire logic [4:0] buf_release_count,
  input wire logic tx_req,
  input wire logic [10:0] tx_len,
  output logic tx_ready,
  output logic tx_done,
  output logic tx_drop,
  output logic mii_transmit_enable,
  input wire logic mii_carrier_sense,
  input wire logic mii_collision
);

  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [3:0] ctrl;
    logic [4:0][4:0] vmem;
    logic [20:0] fwdst;
    logic [47:0] st_mac;
    logic st_v;
    logic [4:0] st_map;
    slf_lk_e ls;
    logic rx_ready;
    logic [IDX_W-1:0] idx;
    logic [47:0] sa;
    logic [47:0] da;
    logic [2:0] port;
    logic [10:0] len;
    logic err;
    logic pause;
    logic vtag;
    logic sa_hit;
    logic [IDX_W-1:0] sa_idx;
    logic da_hit;
    logic [2:0] da_port;
    logic free_ok;
    logic [IDX_W-1:0] free_idx;
    logic fwd_valid;
    logic [4:0] map1;
    logic [4:0] map2;
    logic [4:0] fwd_bufs;
    logic [10:0] count;
    logic [9:0] free_bufs;
    logic [15:0] drops;
    logic [15:0] txdrops;
    logic [31:0] ms_cnt;
    logic [31:0] tick_cnt;
    logic [2:0] epoch;
    logic [IDX_W-1:0] age_idx;
    slf_ent_s [TAB_DEPTH-1:0] tab;
    slf_tx_e ts;
    logic txen;
    logic tx_ready;
    logic tx_done;
    logic tx_drop;
    logic retry;
    logic gap_crs;
    logic [19:0] cnt;
    logic [10:0] tlen;
    logic [4:0] coll;
    logic [15:0] lfsr;
  } slf_st_s;

  slf_st_s s;
  slf_st_s n;
  slf_ent_s e;
  slf_ent_s ae;
  logic good;
  logic mc;
  logic local_hit;
  logic drop;
  logic [10:0] maxlen;
  logic [4:0] need;
  logic [4:0] vm;
  logic [4:0] map1;
  logic [4:0] map2;
  logic [IDX_W-1:0] widx;
  logic [4:0] ncoll;
  logic [9:0] slots;

  function automatic logic [4:0] onehot(input logic [2:0] p);
    return 5'(6'h01 << p);
  endfunction

  function automatic logic [9:0] bo_mask(input logic [4:0] c, input logic aggr);
    logic [4:0] k;
    k = (c > 5'(BO_EXP_STD)) ? 5'(BO_EXP_STD) : c;
    if (aggr && k > 5'(BO_EXP_AGGR)) begin
      k = 5'(BO_EXP_AGGR);
    end
    return 10'((11'h001 << k) - 11'h001);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    e = s.tab[s.idx];
    ae = s.tab[s.age_idx];
    good = 1'b0;
    mc = 1'b0;
    local_hit = 1'b0;
    drop = 1'b0;
    maxlen = (s.ctrl[C_HUGE] ? MAX_HUGE : MAX_STD) + (s.vtag ? VLAN_TAG_BYTES : 11'h000);
    need = 5'(({1'b0, s.len} + BUF_ROUND) >> BUF_SHIFT);
    vm = s.vmem[s.port];
    map1 = ALL_PORTS;
    map2 = 5'h00;
    widx = s.free_ok ? s.free_idx : IDX_LAST;
    ncoll = s.coll + 5'h01;
    slots = s.lfsr[9:0] & bo_mask(ncoll, s.ctrl[C_AGGR]);
    n.fwd_valid = 1'b0;
    n.tx_done = 1'b0;
    n.tx_drop = 1'b0;
    n.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};

    // Register writes in data phase
    if (s.wr_pend) begin
      case (s.wr_addr)
        A_CTRL: n.ctrl = hwdata[3:0];
        A_VMEM: n.vmem = hwdata[24:0];
        A_FWD: n.fwdst = hwdata[20:0];
        A_SLO: n.st_mac[31:0] = hwdata;
        A_SHI: begin
          n.st_mac[47:32] = hwdata[15:0];
          n.st_v = hwdata[16];
          n.st_map = hwdata[28:24];
        end
        default: ;
      endcase
    end
    n.wr_pend = hsel & hready & htrans[1] & hwrite;
    n.wr_addr = {haddr[7:2], 2'b00};

    // Aging timebase
    if (s.ms_cnt == 32'(MS_CYCLES - 1)) begin
      n.ms_cnt = 32'h0;
      if (s.tick_cnt == 32'(TICK_MS - 1)) begin
        n.tick_cnt = 32'h0;
        n.epoch = s.epoch + 3'h1;
      end else begin
        n.tick_cnt = s.tick_cnt + 32'h1;
      end
    end else begin
      n.ms_cnt = s.ms_cnt + 32'h1;
    end

    // Buffer return from egress
    if (buf_release) begin
      n.free_bufs = s.free_bufs + {5'h00, buf_release_count};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lookup engine
    unique case (s.ls)
      LK_IDLE: begin
        if (rx_valid && s.rx_ready) begin
          n.sa = rx_sa;
          n.da = rx_da;
          n.port = rx_port;
          n.len = rx_len;
          n.err = rx_err;
          n.pause = rx_pause;
          n.vtag = rx_vlan_tag;
          n.idx = '0;
          n.sa_hit = 1'b0;
          n.da_hit = 1'b0;
          n.free_ok = 1'b0;
          n.ls = LK_SCAN;
        end else begin
          if (s.ctrl[C_AGE_EN] && ae.v && 3'(s.epoch - ae.stamp) >= AGE_STALE) begin
            n.tab[s.age_idx].v = 1'b0;
            n.count = s.count - 11'h001;
          end
          n.age_idx = s.age_idx + 10'h001;
        end
      end
      LK_SCAN: begin
        if (e.v && e.mac == s.sa && !s.sa_hit) begin
          n.sa_hit = 1'b1;
          n.sa_idx = s.idx;
        end
        if (e.v && e.mac == s.da && !s.da_hit) begin
          n.da_hit = 1'b1;
          n.da_port = e.port;
        end
        if (!e.v && !s.free_ok) begin
          n.free_ok = 1'b1;
          n.free_idx = s.idx;
        end
        if (s.idx == IDX_LAST) begin
          n.ls = LK_DECIDE;
        end else begin
          n.idx = s.idx + 10'h001;
        end
      end
      LK_DECIDE: begin
        good = ~s.err & (s.len >= MIN_FRAME) & (s.len <= maxlen);
        if (s.sa_hit) begin
          n.tab[s.sa_idx].stamp = s.epoch;
          if (good && s.tab[s.sa_idx].port != s.port) begin
            n.tab[s.sa_idx].port = s.port;
          end
        end else if (good) begin
          n.tab[widx] = '{v: 1'b1, mac: s.sa, port: s.port, stamp: s.epoch};
          if (s.free_ok) begin
            n.count = n.count + 11'h001;
          end
        end
        mc = s.da[40];
        local_hit = s.da_hit & ~mc & (s.da_port == s.port);
        if (s.st_v && s.st_mac == s.da) begin
          map1 = s.st_map;
        end else if (s.da_hit && !mc) begin
          map1 = onehot(s.da_port);
        end
        map2 = map1 & vm & s.fwdst[4:0];
        if (s.fwdst[F_MIR_EN] && s.fwdst[8 + 32'(s.port)]) begin
          map2 = map2 | onehot(s.fwdst[18:16]);
        end
        map2 = map2 & ~onehot(s.port);
        drop = ~good | s.pause | local_hit | (map2 == 5'h00) |
               (n.free_bufs < {5'h00, need});
        n.fwd_valid = 1'b1;
        n.map1 = map1;
        n.map2 = drop ? 5'h00 : map2;
        n.fwd_bufs = drop ? 5'h00 : need;
        if (drop) begin
          n.drops = s.drops + 16'h0001;
        end else begin
          n.free_bufs = n.free_bufs - {5'h00, need};
        end
        n.ls = LK_IDLE;
      end
    endcase
    n.rx_ready = (n.ls == LK_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit timing
    unique case (s.ts)
      TX_IDLE: begin
        if (tx_req && s.tx_ready) begin
          n.tlen = tx_len;
          n.coll = 5'h00;
          n.cnt = 20'h0;
          n.txen = 1'b1;
          n.ts = TX_SEND;
        end
      end
      TX_SEND: begin
        n.cnt = s.cnt + 20'h1;
        if (mii_collision) begin
          n.txen = 1'b0;
          n.cnt = 20'h0;
          n.gap_crs = 1'b1;
          if (s.cnt >= 20'(SLOT_CYC)) begin
            n.tx_drop = 1'b1;
            n.txdrops = s.txdrops + 16'h0001;
            n.retry = 1'b0;
            n.ts = TX_GAP;
          end else if (ncoll == 5'(MAX_COLL) && s.ctrl[C_DROP_XS]) begin
            n.tx_drop = 1'b1;
            n.txdrops = s.txdrops + 16'h0001;
            n.retry = 1'b0;
            n.ts = TX_GAP;
          end else begin
            n.coll = (ncoll == 5'(MAX_COLL)) ? 5'h00 : ncoll;
            n.cnt = 20'(slots) * 20'(SLOT_CYC);
            n.retry = 1'b1;
            n.ts = TX_BACK;
          end
        end else if (s.cnt == 20'(s.tlen) * 20'(BYTE_CYC) - 20'h1) begin
          n.txen = 1'b0;
          n.tx_done = 1'b1;
          n.cnt = 20'h0;
          n.gap_crs = 1'b0;
          n.retry = 1'b0;
          n.ts = TX_GAP;
        end
      end
      TX_BACK: begin
        if (s.cnt == 20'h0) begin
          n.ts = TX_GAP;
        end else begin
          n.cnt = s.cnt - 20'h1;
        end
      end
      TX_GAP: begin
        if (s.gap_crs && mii_carrier_sense) begin
          n.cnt = 20'h0;
        end else if (s.cnt == 20'(IPG_CYC - 1)) begin
          n.cnt = 20'h0;
          if (s.retry) begin
            n.txen = 1'b1;
            n.ts = TX_SEND;
          end else begin
            n.ts = TX_IDLE;
          end
        end else begin
          n.cnt = s.cnt + 20'h1;
        end
      end
    endcase
    n.tx_ready = (n.ts == TX_IDLE);

    // Read data for the next data phase
    n.hrdata = 32'h0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        A_CTRL: n.hrdata = {28'h0, n.ctrl};
        A_VMEM: n.hrdata = {7'h00, n.vmem};
        A_FWD: n.hrdata = {11'h000, n.fwdst};
        A_SLO: n.hrdata = n.st_mac[31:0];
        A_SHI: n.hrdata = {3'h0, n.st_map, 7'h00, n.st_v, n.st_mac[47:32]};
        A_STAT: n.hrdata = {6'h00, n.free_bufs, 5'h00, n.count};
        A_DROP: n.hrdata = {n.txdrops, n.drops};
        default: n.hrdata = 32'h0;
      endcase
    end
    n.hreadyout = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.hreadyout <= 1'b1;
      s.ctrl <= CTRL_RST;
      s.vmem <= VMEM_RST;
      s.fwdst <= FWD_RST;
      s.free_bufs <= BUF_COUNT;
      s.rx_ready <= 1'b1;
      s.tx_ready <= 1'b1;
      s.lfsr <= LFSR_SEED;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = 1'b0;
  assign rx_ready = s.rx_ready;
  assign fwd_valid = s.fwd_valid;
  assign first_stage_port_map = s.map1;
  assign final_port_map = s.map2;
  assign fwd_buffers = s.fwd_bufs;
  assign tx_ready = s.tx_ready;
  assign tx_done = s.tx_done;
  assign tx_drop = s.tx_drop;
  assign mii_transmit_enable = s.txen;

endmodule

// ### rtl/slf_pkg.sv
// Shared constants and types of the switch lookup, forwarding and transmit block.
// Assumes one 125 MHz system clock and 100 Mb/s port bit time.
package slf_pkg;

  // Clock and line timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int BIT_TIME_PS = 10000;
  localparam int IPG_BITS = 96;
  localparam int SLOT_BITS = 512;
  localparam int IPG_CYC = (IPG_BITS * BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLOT_CYC = (SLOT_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
  localparam int BYTE_CYC = (8 * BIT_TIME_PS) / CLK_PERIOD_PS;
  localparam int MAX_COLL = 16;
  localparam int BO_EXP_STD = 10;
  localparam int BO_EXP_AGGR = 3;

  // Aging timebase
  localparam int AGE_PERIOD_S = 300;
  localparam int AGE_TOL_S = 75;
  localparam int AGE_TICK_S = AGE_TOL_S;
  localparam int MS_PER_S = 1000;
  localparam int PS_PER_MS = 1000000000;
  localparam int DEF_MS_CYCLES = PS_PER_MS / CLK_PERIOD_PS;
  localparam int DEF_TICK_MS = AGE_TICK_S * MS_PER_S;
  localparam logic [2:0] AGE_STALE = 3'(AGE_PERIOD_S / AGE_TICK_S);

  // Address table
  localparam int TAB_DEPTH = 1024;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_LAST = 10'h3ff;
  localparam int NPORTS = 5;
  localparam logic [4:0] ALL_PORTS = 5'h1f;

  // Frame sizes and buffer pool
  localparam logic [10:0] MIN_FRAME = 11'h040;
  localparam logic [10:0] MAX_STD = 11'h600;
  localparam logic [10:0] MAX_HUGE = 11'h77c;
  localparam logic [10:0] VLAN_TAG_BYTES = 11'h004;
  localparam logic [9:0] BUF_COUNT = 10'h200;
  localparam logic [11:0] BUF_ROUND = 12'h07f;
  localparam int BUF_SHIFT = 7;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_VMEM = 8'h04;
  localparam logic [7:0] A_FWD = 8'h08;
  localparam logic [7:0] A_SLO = 8'h0c;
  localparam logic [7:0] A_SHI = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_DROP = 8'h18;

  // Control fields and reset values
  localparam int C_AGE_EN = 0;
  localparam int C_DROP_XS = 1;
  localparam int C_AGGR = 2;
  localparam int C_HUGE = 3;
  localparam int F_MIR_EN = 20;
  localparam logic [3:0] CTRL_RST = 4'h3;
  localparam logic [24:0] VMEM_RST = 25'h1ffffff;
  localparam logic [20:0] FWD_RST = 21'h00001f;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef struct packed {
    logic v;
    logic [47:0] mac;
    logic [2:0] port;
    logic [2:0] stamp;
  } slf_ent_s;

  typedef enum logic [1:0] {LK_IDLE = 2'b00, LK_SCAN = 2'b01, LK_DECIDE = 2'b11} slf_lk_e;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SEND = 2'b01, TX_BACK = 2'b11,
                            TX_GAP = 2'b10} slf_tx_e;

endpackage

// ### tb/slf_assertions.sv
// Checker of lookup latency, forwarding results and transmit timing.
// Bound into slf_top; sees its ports only.
`timescale 1ns/1ps
module slf_assertions
  import slf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic fwd_valid,
  input wire logic [4:0] final_port_map,
  input wire logic [4:0] fwd_buffers,
  input wire logic tx_req,
  input wire logic tx_ready,
  input wire logic tx_done,
  input wire logic tx_drop,
  input wire logic mii_transmit_enable,
  input wire logic mii_carrier_sense,
  input wire logic mii_collision
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic [10:0] lk;
  logic [11:0] low;
  logic [11:0] quiet;
  logic [11:0] sc;
  // Cycles since take, since enable and carrier fell, while sending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk <= '0;
      low <= 12'hfff;
      quiet <= 12'hfff;
      sc <= '0;
    end else begin
      if (rx_valid && rx_ready) lk <= 11'h001;
      else if (fwd_valid) lk <= '0;
      else if (lk != '0) lk <= lk + 11'h001;
      if (mii_transmit_enable) low <= '0;
      else if (low != 12'hfff) low <= low + 12'h001;
      if (mii_carrier_sense) quiet <= '0;
      else if (quiet != 12'hfff) quiet <= quiet + 12'h001;
      sc <= mii_transmit_enable ? sc + 12'h001 : '0;
    end
  end
  ////////////////////////////////////////
  a_fwd_latency: assert property ((lk == 11'h402) == fwd_valid)
    else $error("forward result off its cycle");
  a_busy_refuse: assert property (lk != '0 && !fwd_valid |-> !rx_ready)
    else $error("lookup ready while busy");
  a_drop_nobuf: assert property (fwd_valid && final_port_map == 5'h00 |-> fwd_buffers == 5'h00)
    else $error("dropped frame holds buffers");
  a_buf_bound: assert property (fwd_valid && final_port_map != 5'h00
    |-> fwd_buffers != 5'h00 && fwd_buffers <= 5'h0f)
    else $error("buffer count out of range");
  a_tx_accept: assert property (tx_req && tx_ready |=> mii_transmit_enable && !tx_ready)
    else $error("transmit not started");
  a_ipg_txen: assert property ($rose(mii_transmit_enable) |-> low >= IPG_CYC)
    else $error("gap after enable too short");
  a_ipg_carrier: assert property ($rose(mii_transmit_enable) |-> quiet >= IPG_CYC)
    else $error("gap after carrier too short");
  a_coll_stop: assert property (mii_collision && mii_transmit_enable
    |=> !mii_transmit_enable)
    else $error("send goes on after collision");
  a_late_drop: assert property (mii_collision && mii_transmit_enable && sc > 12'h280
    |-> ##[1:3] tx_drop)
    else $error("late collision not dropped");
  a_done_edge: assert property (tx_done |-> $fell(mii_transmit_enable))
    else $error("done without enable falling");
endmodule
bind slf_top slf_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .fwd_valid(fwd_valid), .final_port_map(final_port_map),
  .fwd_buffers(fwd_buffers), .tx_req(tx_req), .tx_ready(tx_ready), .tx_done(tx_done),
  .tx_drop(tx_drop), .mii_transmit_enable(mii_transmit_enable),
  .mii_carrier_sense(mii_carrier_sense), .mii_collision(mii_collision));

// ### tb/slf_phy_model.sv
// Far side of the transmit port: carrier sense and commanded collisions.
// Assumes the clock of slf_top and a bench that sets the collision plan.
`timescale 1ns/1ps
module slf_phy_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic txen,
  input wire logic clr,
  input wire logic [11:0] coll_at,
  input wire logic [4:0] coll_n,
  output logic crs,
  output logic col
);
  logic [11:0] sc;
  logic [5:0] hold;
  logic [4:0] made;
  // Collide at a set send cycle, then hold carrier for a remote frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sc <= '0;
      hold <= '0;
      made <= '0;
      col <= 1'b0;
    end else begin
      col <= 1'b0;
      if (clr) made <= '0;
      if (txen && !col) begin
        sc <= sc + 12'h001;
        if (sc == coll_at && made < coll_n) begin
          col <= 1'b1;
          made <= made + 5'h01;
          hold <= 6'h28;
        end
      end else begin
        sc <= '0;
        if (hold != '0) hold <= hold - 6'h01;
      end
    end
  end
  assign crs = txen || hold != '0;
endmodule

// ### tb/tb_top.sv
// Bench of the switch core: registers, lookup, aging, buffers, transmit.
// Assumes the far-side model on the transmit port and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import slf_pkg::*;
  localparam int LIMIT = 110000;
  localparam logic [47:0] MA = 48'h0200_0000_000a;
  localparam logic [47:0] MB = 48'h0200_0000_000b;
  localparam logic [47:0] MC = 48'h0200_0000_000c;
  localparam logic [47:0] MD = 48'h0200_0000_000d;
  localparam logic [47:0] ME = 48'h0200_0000_000e;
  localparam logic [47:0] MG = 48'h0200_0000_0010;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rx_ready, fwd_valid, tx_ready, tx_done, tx_drop, txen, crs, col;
  logic rx_valid = 1'b0;
  logic [47:0] rx_sa = '0;
  logic [47:0] rx_da = '0;
  logic [2:0] rx_port = '0;
  logic [10:0] rx_len = '0;
  logic [10:0] tx_len = 11'h040;
  logic rx_err = 1'b0;
  logic rx_pause = 1'b0;
  logic rx_vlan_tag = 1'b0;
  logic [4:0] m1, m2, nb;
  logic buf_release = 1'b0;
  logic [4:0] buf_release_count = '0;
  logic tx_req = 1'b0;
  logic clr = 1'b0;
  logic [11:0] coll_at = '0;
  logic [4:0] coll_n = '0;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] ra [6] = '{A_CTRL, A_VMEM, A_FWD, A_STAT, A_DROP, 8'h1c};
  logic [31:0] rv [6] = '{32'h3, 32'h1ffffff, 32'h1f, 32'h02000000, 32'h0, 32'h0};
  // Length, then huge, tagged, accepted
  logic [13:0] sz [10] = '{{11'h03f, 3'h0}, {11'h040, 3'h1}, {11'h600, 3'h1},
    {11'h601, 3'h0}, {11'h604, 3'h3}, {11'h605, 3'h2}, {11'h77c, 3'h5}, {11'h77d, 3'h4},
    {11'h780, 3'h7}, {11'h781, 3'h6}};

  slf_top #(.MS_CYCLES(5), .TICK_MS(17)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_sa(rx_sa), .rx_da(rx_da),
    .rx_port(rx_port), .rx_len(rx_len), .rx_err(rx_err), .rx_pause(rx_pause),
    .rx_vlan_tag(rx_vlan_tag), .fwd_valid(fwd_valid), .first_stage_port_map(m1),
    .final_port_map(m2), .fwd_buffers(nb), .buf_release(buf_release),
    .buf_release_count(buf_release_count), .tx_req(tx_req), .tx_len(tx_len),
    .tx_ready(tx_ready), .tx_done(tx_done), .tx_drop(tx_drop), .mii_transmit_enable(txen),
    .mii_carrier_sense(crs), .mii_collision(col));
  slf_phy_model phy (.hclk(hclk), .hresetn(hresetn), .txen(txen), .clr(clr),
    .coll_at(coll_at), .coll_n(coll_n), .crs(crs), .col(col));

  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      $display("ERROR t=%0t timeout got=%h exp=%h", $time, cyc, LIMIT);
      results();
    end
  end
  ////////////////////////////////////////
  task automatic results();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic ahb_addr(input logic [7:0] a, input logic w);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] v);
    ahb_addr(a, 1'b1);
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] v);
    ahb_addr(a, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  // Offer one descriptor, await its result, compare both maps and buffers
  task automatic send(input logic [47:0] sa, input logic [47:0] da, input logic [2:0] p,
    input logic [10:0] ln, input logic [2:0] f, input logic [14:0] e);
    int n;
    rx_sa <= sa;
    rx_da <= da;
    rx_port <= p;
    rx_len <= ln;
    {rx_err, rx_pause, rx_vlan_tag} <= f;
    rx_valid <= 1'b1;
    do @(posedge hclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (fwd_valid !== 1'b1 && n < 2000);
    chk({m1, m2, nb}, e);
  endtask
  // Send one frame; e is done, drop and attempt count
  task automatic tx(input logic [10:0] ln, input logic [11:0] at, input logic [4:0] cn,
    input logic [6:0] e);
    int n;
    int hi;
    logic [4:0] att;
    logic pv;
    coll_at <= at;
    coll_n <= cn;
    clr <= 1'b1;
    tx_len <= ln;
    tx_req <= 1'b1;
    do @(posedge hclk); while (tx_ready !== 1'b1);
    tx_req <= 1'b0;
    clr <= 1'b0;
    n = 0;
    hi = 0;
    att = '0;
    pv = 1'b0;
    do begin
      @(posedge hclk);
      n++;
      if (txen === 1'b1 && !pv) att++;
      if (txen === 1'b1 && !pv) hi = 0;
      if (txen === 1'b1) hi++;
      pv = (txen === 1'b1);
    end while (tx_done !== 1'b1 && tx_drop !== 1'b1 && n < 90000);
    chk({tx_done, tx_drop, att}, e);
    if (e[6]) chk(hi, ln * 10);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [11:0] b;
    logic [14:0] e;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      ahb_rd(ra[i], d);
      chk(d, rv[i]);
    end
    ahb_wr(A_STAT, 32'hffffffff);
    ahb_wr(8'h1c, 32'h5);
    ahb_rd(A_STAT, d);
    chk(d, 32'h02000000);
    ahb_rd(8'h1c, d);
    chk(d, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    ahb_wr(A_CTRL, 32'h6);
    ahb_rd(A_CTRL, d);
    chk(d, 32'h6);
    $display("register test done");
    send(MA, MB, 3'h1, 11'h040, 3'h0, {5'h1f, 5'h1d, 5'h01});
    send(MB, MA, 3'h2, 11'h080, 3'h0, {5'h02, 5'h02, 5'h01});
    send(MC, MA, 3'h1, 11'h081, 3'h0, {5'h02, 5'h00, 5'h00});
    send(MA, MC, 3'h3, 11'h040, 3'h0, {5'h02, 5'h02, 5'h01});
    send(MD, MA, 3'h2, 11'h040, 3'h0, {5'h08, 5'h08, 5'h01});
    send(ME, MB, 3'h0, 11'h040, 3'h4, {5'h04, 5'h00, 5'h00});
    send(MG, ME, 3'h4, 11'h040, 3'h0, {5'h1f, 5'h0f, 5'h01});
    send(MG, MB, 3'h4, 11'h040, 3'h2, {5'h04, 5'h00, 5'h00});
    for (int i = 0; i < 10; i++) begin
      ahb_wr(A_CTRL, {28'h0, sz[i][2], 3'h6});
      b = ({1'b0, sz[i][13:3]} + 12'h07f) >> 7;
      e = sz[i][0] ? {5'h04, 5'h04, b[4:0]} : {5'h04, 10'h000};
      send(MG, MB, 3'h4, sz[i][13:3], {2'h0, sz[i][1]}, e);
    end
    buf_release_count <= 5'h1f;
    buf_release <= 1'b1;
    @(posedge hclk);
    buf_release <= 1'b0;
    @(posedge hclk);
    ahb_rd(A_STAT, d);
    chk(d, {6'h00, 10'h1e2, 5'h00, 11'h005});
    $display("forwarding test done");
    repeat (3000) @(posedge hclk);
    ahb_rd(A_STAT, d);
    chk(d[10:0], 11'h005);
    ahb_wr(A_CTRL, 32'h7);
    repeat (5000) @(posedge hclk);
    ahb_rd(A_STAT, d);
    chk(d[10:0], 11'h000);
    send(MA, MB, 3'h0, 11'h040, 3'h0, {5'h1f, 5'h1e, 5'h01});
    // Static entry, mirror of port 2 to port 3, port 2 barred from port 1
    ahb_wr(A_SLO, 32'h0000000d);
    ahb_wr(A_SHI, 32'h13010200);
    ahb_wr(A_FWD, 32'h0013041f);
    ahb_wr(A_VMEM, 32'h01fff7ff);
    ahb_rd(A_SHI, d);
    chk(d, 32'h13010200);
    send(MB, MD, 3'h2, 11'h040, 3'h0, {5'h13, 5'h19, 5'h01});
    $display("aging test done");
    ahb_wr(A_CTRL, 32'h6);
    repeat (2) tx(11'h040, 12'h000, 5'h00, 7'h41);
    tx(11'h040, 12'h032, 5'h01, 7'h42);
    tx(11'h064, 12'h2bc, 5'h01, 7'h21);
    tx(11'h040, 12'h014, 5'h10, 7'h30);
    ahb_rd(A_DROP, d);
    chk(d, {16'h0002, 16'h0008});
    $display("transmit test done");
    results();
  end
endmodule
